// ==== core/psp_datapath.sv ====
// Packed permute, blend, multiply, insert/extract and widening datapath.
// Assumes the issue logic presents one operation per cycle with operands.
`timescale 1ns/1ps
`include "psp_map.svh"
module psp_datapath (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Issue side
  input wire logic issue_valid,
  input wire psp_pkg::psp_op_t issue_op,
  input wire logic narrow64,
  input wire logic src_is_mem,
  input wire logic [`PSP_IMM_W-1:0] imm,
  input wire logic [`PSP_V_W-1:0] dst_a,
  input wire logic [`PSP_V_W-1:0] src_b,
  input wire logic [`PSP_V_W-1:0] mask_m,
  input wire logic [`PSP_Q_W-1:0] gpr_in,
  // Result side
  output logic res_valid,
  output logic [`PSP_V_W-1:0] vec_out,
  output logic [`PSP_Q_W-1:0] gpr_out
);

  localparam int B = `PSP_B_W;
  localparam int W = `PSP_W_W;
  localparam int D = `PSP_D_W;
  localparam int Q = `PSP_Q_W;
  localparam int V = `PSP_V_W;

  psp_pkg::psp_state_t state;
  psp_pkg::psp_state_t next_state;

  wire logic [V-1:0] shuf_v;
  wire logic [V-1:0] sgn_b;
  wire logic [V-1:0] sgn_w;
  wire logic [V-1:0] sgn_d;
  wire logic [V-1:0] bl_vb;
  wire logic [V-1:0] bl_w;
  wire logic [V-1:0] bl_s;
  wire logic [V-1:0] bl_vs;
  wire logic [V-1:0] bl_d;
  wire logic [V-1:0] bl_vd;
  wire logic [V-1:0] mul_lo;
  wire logic [V-1:0] mul_wd;
  wire logic [V-1:0] ins_ps;
  wire logic [V-1:0] ins_b;
  wire logic [V-1:0] ins_d;
  wire logic [V-1:0] ins_q;
  wire logic [V-1:0] sx_bw;
  wire logic [V-1:0] zx_bw;
  wire logic [V-1:0] sx_bd;
  wire logic [V-1:0] zx_bd;
  wire logic [V-1:0] sx_wd;
  wire logic [V-1:0] zx_wd;
  wire logic [V-1:0] sx_bq;
  wire logic [V-1:0] zx_bq;
  wire logic [V-1:0] sx_wq;
  wire logic [V-1:0] zx_wq;
  wire logic [V-1:0] sx_dq;
  wire logic [V-1:0] zx_dq;
  wire logic [V-1:0] mm_v;
  wire logic [Q-1:0] prod [`PSP_NDWORDS];

  // ****************************************
  // Align right
  // ****************************************
  // Shifting in zeros gives an all-zero slice once the offset passes both
  wire logic [2*V-1:0] al_cat = narrow64 ?
    {{V{1'b0}}, dst_a[Q-1:0], src_b[Q-1:0]} : {dst_a, src_b}; // RL5
  wire logic [2*V-1:0] al_sh = al_cat >> {imm, 3'h0};
  wire logic [V-1:0] al_v = al_sh[V-1:0]; // RL6

  // Insert helpers
  wire logic [`PSP_IDX128_W-1:0] ib_idx = narrow64 ?
    {1'b0, imm[`PSP_IDX64_W-1:0]} : imm[`PSP_IDX128_W-1:0];
  wire logic [1:0] ps_src = imm[`PSP_INS_SRC_HI:`PSP_INS_SRC_LO];
  wire logic [1:0] ps_dst = imm[`PSP_INS_DST_HI:`PSP_INS_DST_LO];
  wire logic [D-1:0] ps_val = src_is_mem ? gpr_in[D-1:0]
                                         : src_b[D*ps_src +: D];

  // ****************************************
  // Per-lane logic
  // ****************************************
  for (genvar i = 0; i < `PSP_NBYTES; i++)
  begin : g_lane
    // Bytes
    wire logic [`PSP_IDX128_W-1:0] ix16 = src_b[B*i +: `PSP_IDX128_W];
    wire logic [`PSP_IDX64_W-1:0] ix8 = src_b[B*i +: `PSP_IDX64_W];
    wire logic [B-1:0] sh = narrow64 ?
      ((i < `PSP_HALF_BYTES) ? dst_a[B*ix8 +: B] : '0) // RL19
      : dst_a[B*ix16 +: B]; // RL1
    assign shuf_v[B*i +: B] = src_b[B*i + B-1] ? '0 : sh; // RL2
    assign sgn_b[B*i +: B] = src_b[B*i + B-1] ? B'(-dst_a[B*i +: B]) // RL4
      : (src_b[B*i +: B] == '0) ? '0 : dst_a[B*i +: B]; // RL20
    assign bl_vb[B*i +: B] = mask_m[B*i + B-1] ?
      src_b[B*i +: B] : dst_a[B*i +: B]; // RL10
    assign ins_b[B*i +: B] = (ib_idx == i) ?
      gpr_in[B-1:0] : dst_a[B*i +: B]; // RL15
    // Words
    if (i < `PSP_NWORDS)
    begin : g_w
      assign sgn_w[W*i +: W] = src_b[W*i + W-1] ? W'(-dst_a[W*i +: W]) // RL4
        : (src_b[W*i +: W] == '0) ? '0 : dst_a[W*i +: W]; // RL20
      assign bl_w[W*i +: W] = imm[i] ? src_b[W*i +: W] : dst_a[W*i +: W]; // RL9
      assign sx_bw[W*i +: W] = W'($signed(src_b[B*i +: B])); // RL17
      assign zx_bw[W*i +: W] = W'(src_b[B*i +: B]); // RL18
    end
    // Dwords
    if (i < `PSP_NDWORDS)
    begin : g_d
      wire logic signed [Q-1:0] ea = Q'($signed(dst_a[D*i +: D]));
      wire logic signed [Q-1:0] eb = Q'($signed(src_b[D*i +: D]));
      assign prod[i] = ea * eb;
      assign mul_lo[D*i +: D] = prod[i][D-1:0]; // RL7
      assign sgn_d[D*i +: D] = src_b[D*i + D-1] ? D'(-dst_a[D*i +: D]) // RL4
        : (src_b[D*i +: D] == '0) ? '0 : dst_a[D*i +: D]; // RL20
      assign bl_s[D*i +: D] = imm[i] ? src_b[D*i +: D] : dst_a[D*i +: D]; // RL9
      assign bl_vs[D*i +: D] = mask_m[D*i + D-1] ?
        src_b[D*i +: D] : dst_a[D*i +: D]; // RL10
      // Mask clears after the insert so a masked target lane reads zero
      assign ins_ps[D*i +: D] = imm[i] ? '0
        : (ps_dst == i) ? ps_val : dst_a[D*i +: D]; // RL14
      assign ins_d[D*i +: D] = (imm[1:0] == i) ?
        gpr_in[D-1:0] : dst_a[D*i +: D]; // RL15
      assign sx_bd[D*i +: D] = D'($signed(src_b[B*i +: B])); // RL17
      assign zx_bd[D*i +: D] = D'(src_b[B*i +: B]); // RL18
      assign sx_wd[D*i +: D] = D'($signed(src_b[W*i +: W])); // RL17
      assign zx_wd[D*i +: D] = D'(src_b[W*i +: W]); // RL18
    end
    // Qwords
    if (i < `PSP_NQWORDS)
    begin : g_q
      assign mul_wd[Q*i +: Q] = prod[2*i]; // RL8
      assign bl_d[Q*i +: Q] = imm[i] ? src_b[Q*i +: Q] : dst_a[Q*i +: Q]; // RL9
      assign bl_vd[Q*i +: Q] = mask_m[Q*i + Q-1] ?
        src_b[Q*i +: Q] : dst_a[Q*i +: Q]; // RL10
      assign ins_q[Q*i +: Q] = (imm[0] == i) ?
        gpr_in : dst_a[Q*i +: Q]; // RL15
      assign sx_bq[Q*i +: Q] = Q'($signed(src_b[B*i +: B])); // RL17
      assign zx_bq[Q*i +: Q] = Q'(src_b[B*i +: B]); // RL18
      assign sx_wq[Q*i +: Q] = Q'($signed(src_b[W*i +: W])); // RL17
      assign zx_wq[Q*i +: Q] = Q'(src_b[W*i +: W]); // RL18
      assign sx_dq[Q*i +: Q] = Q'($signed(src_b[D*i +: D])); // RL17
      assign zx_dq[Q*i +: Q] = Q'(src_b[D*i +: D]); // RL18
    end
  end

  // ****************************************
  // Min and max
  // ****************************************
  wire logic mm_max = issue_op inside {psp_pkg::max_unsigned_word_op,
    psp_pkg::max_unsigned_dword_op, psp_pkg::max_signed_byte_op,
    psp_pkg::max_signed_dword_op};
  wire logic mm_sgn = issue_op inside {psp_pkg::min_signed_byte_op,
    psp_pkg::min_signed_dword_op, psp_pkg::max_signed_byte_op,
    psp_pkg::max_signed_dword_op};
  psp_pkg::psp_size_t mm_size;

  // Lane size of the compare variant
  always_comb
  begin
    case (issue_op)
      psp_pkg::min_signed_byte_op: mm_size = psp_pkg::psp_sz_byte;
      psp_pkg::max_signed_byte_op: mm_size = psp_pkg::psp_sz_byte;
      psp_pkg::min_unsigned_word_op: mm_size = psp_pkg::psp_sz_word;
      psp_pkg::max_unsigned_word_op: mm_size = psp_pkg::psp_sz_word;
      default: mm_size = psp_pkg::psp_sz_dword;
    endcase
  end

  psp_minmax u_minmax (
    .a(dst_a),
    .b(src_b),
    .lane_size(mm_size),
    .is_signed(mm_sgn),
    .take_max(mm_max),
    .res(mm_v)
  );

  // ****************************************
  // Result select
  // ****************************************
  // Result holds between issues; only the valid flag pulses
  always_comb
  begin
    logic [V-1:0] vec;
    logic [Q-1:0] scal;
    vec = dst_a;
    scal = `PSP_RST_SCALAR;
    next_state = state;
    next_state.valid = issue_valid;
    case (issue_op)
      psp_pkg::byte_shuffle_op: vec = shuf_v; // RL3
      psp_pkg::packed_sign_byte_op: vec = sgn_b;
      psp_pkg::packed_sign_word_op: vec = sgn_w;
      psp_pkg::packed_sign_dword_op: vec = sgn_d;
      psp_pkg::align_right_op: vec = al_v;
      psp_pkg::dword_mul_low_op: vec = mul_lo;
      psp_pkg::dword_mul_wide_op: vec = mul_wd;
      psp_pkg::blend_double_imm_op: vec = bl_d;
      psp_pkg::blend_single_imm_op: vec = bl_s;
      psp_pkg::blend_word_imm_op: vec = bl_w;
      psp_pkg::blend_double_mask_op: vec = bl_vd;
      psp_pkg::blend_single_mask_op: vec = bl_vs;
      psp_pkg::blend_byte_mask_op: vec = bl_vb;
      psp_pkg::single_lane_extract_op:
        scal = Q'(src_b[D*imm[1:0] +: D]); // RL13
      psp_pkg::single_lane_insert_op: vec = ins_ps;
      psp_pkg::byte_insert_op: vec = ins_b;
      psp_pkg::dword_insert_op: vec = ins_d;
      psp_pkg::qword_insert_op: vec = ins_q;
      psp_pkg::byte_extract_op: scal = Q'(src_b[B*imm[3:0] +: B]); // RL16
      psp_pkg::word_extract_op: scal = Q'(src_b[W*imm[2:0] +: W]); // RL16
      psp_pkg::dword_extract_op: scal = Q'(src_b[D*imm[1:0] +: D]); // RL16
      psp_pkg::qword_extract_op: scal = src_b[Q*imm[0] +: Q]; // RL16
      psp_pkg::sext_byte_to_word_op: vec = sx_bw;
      psp_pkg::zext_byte_to_word_op: vec = zx_bw;
      psp_pkg::sext_byte_to_dword_op: vec = sx_bd;
      psp_pkg::zext_byte_to_dword_op: vec = zx_bd;
      psp_pkg::sext_word_to_dword_op: vec = sx_wd;
      psp_pkg::zext_word_to_dword_op: vec = zx_wd;
      psp_pkg::sext_byte_to_qword_op: vec = sx_bq;
      psp_pkg::zext_byte_to_qword_op: vec = zx_bq;
      psp_pkg::sext_word_to_qword_op: vec = sx_wq;
      psp_pkg::zext_word_to_qword_op: vec = zx_wq;
      psp_pkg::sext_dword_to_qword_op: vec = sx_dq;
      psp_pkg::zext_dword_to_qword_op: vec = zx_dq;
      default: vec = mm_v;
    endcase
    // 64-bit shuffle, sign and align forms leave the upper half clear
    if (narrow64 && issue_op inside {psp_pkg::byte_shuffle_op,
        psp_pkg::packed_sign_byte_op, psp_pkg::packed_sign_word_op,
        psp_pkg::packed_sign_dword_op, psp_pkg::align_right_op})
      vec[V-1:Q] = '0;
    if (issue_valid)
    begin
      next_state.vec = vec;
      next_state.scalar = scal;
    end
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state.valid <= 1'b0;
      state.vec <= `PSP_RST_VEC;
      state.scalar <= `PSP_RST_SCALAR;
    end
    else
      state <= next_state;
  end

  assign res_valid = state.valid;
  assign vec_out = state.vec;
  assign gpr_out = state.scalar;

  // ****************************************
  // Checks
  // ****************************************
  AST_SHUF_ZERO: assert property (@(posedge mclk) disable iff (rst) // RL2
    issue_valid && issue_op == psp_pkg::byte_shuffle_op && src_b[B-1]
    |=> res_valid && vec_out[B-1:0] == '0)
    else $error("shuffle byte with msb set not zero");
  AST_SHUF_IDX: assert property (@(posedge mclk) disable iff (rst) // RL1
    issue_valid && issue_op == psp_pkg::byte_shuffle_op && !narrow64
    && !src_b[B-1] |=> vec_out[B-1:0] == $past(dst_a[B*src_b[3:0] +: B]))
    else $error("shuffle byte index wrong");
  AST_SHUF_NARROW: assert property (@(posedge mclk) disable iff (rst) // RL19
    issue_valid && issue_op == psp_pkg::byte_shuffle_op && narrow64
    && !src_b[B-1] |=> vec_out[B-1:0] == $past(dst_a[B*src_b[2:0] +: B])
    && vec_out[V-1:Q] == '0)
    else $error("narrow shuffle index wrong");
  AST_SIGN_NEG: assert property (@(posedge mclk) disable iff (rst) // RL4
    issue_valid && issue_op == psp_pkg::packed_sign_word_op && src_b[W-1]
    |=> vec_out[W-1:0] == W'(-$past(dst_a[W-1:0])))
    else $error("sign op did not negate");
  AST_SIGN_ZERO: assert property (@(posedge mclk) disable iff (rst) // RL20
    issue_valid && issue_op == psp_pkg::packed_sign_byte_op
    && src_b[B-1:0] == '0 |=> vec_out[B-1:0] == '0)
    else $error("sign op zero source not cleared");
  AST_ALIGN: assert property (@(posedge mclk) disable iff (rst) // RL6
    issue_valid && issue_op == psp_pkg::align_right_op && !narrow64
    && imm == 8'h10 |=> vec_out == $past(dst_a))
    else $error("align offset sixteen not destination");
  AST_MUL_LO: assert property (@(posedge mclk) disable iff (rst) // RL7
    issue_valid && issue_op == psp_pkg::dword_mul_low_op
    |=> vec_out[D-1:0] == D'($past(dst_a[D-1:0]) * $past(src_b[D-1:0])))
    else $error("low multiply lane zero wrong");
  AST_MUL_WD: assert property (@(posedge mclk) disable iff (rst) // RL8
    issue_valid && issue_op == psp_pkg::dword_mul_wide_op
    |=> $signed(vec_out[Q-1:0]) == $signed($past(dst_a[D-1:0]))
        * $signed($past(src_b[D-1:0])))
    else $error("wide multiply lane zero wrong");
  AST_BLEND_W: assert property (@(posedge mclk) disable iff (rst) // RL9
    issue_valid && issue_op == psp_pkg::blend_word_imm_op
    |=> vec_out[W-1:0] == ($past(imm[0]) ? $past(src_b[W-1:0])
                                         : $past(dst_a[W-1:0])))
    else $error("word blend lane zero wrong");
  AST_MIN_UW: assert property (@(posedge mclk) disable iff (rst) // RL11
    issue_valid && issue_op == psp_pkg::min_unsigned_word_op
    |=> vec_out[W-1:0] <= $past(dst_a[W-1:0])
        && vec_out[W-1:0] <= $past(src_b[W-1:0]))
    else $error("unsigned word min too large");
  AST_ZX_BW: assert property (@(posedge mclk) disable iff (rst) // RL18
    issue_valid && issue_op == psp_pkg::zext_byte_to_word_op
    |=> vec_out[W-1:0] == {8'h00, $past(src_b[B-1:0])})
    else $error("zero widen lane zero wrong");

endmodule

// ==== core/psp_map.svh ====
// Named widths, bit positions and reset values for the permute datapath.
// Assumes inclusion by bare name from every design file.
// How it works
// RL1 - Shuffle takes low three or four control bits as source byte index.
// RL2 - Shuffle writes zero where control byte bit 7 is set.
// RL3 - Shuffle leaves the control operand untouched; only result changes.
// RL4 - Sign op negates destination element when source element is negative.
// RL5 - Align forms double width value, source placed after destination.
// RL6 - Align returns operand-width slice right-aligned at immediate byte.
// RL7 - Low multiply keeps low 32 bits of four signed dword products.
// RL8 - Wide multiply returns two full 64-bit signed dword products.
// RL9 - Immediate blends copy source element where immediate bit is set.
// RL10 - Mask blends copy source element where mask element msb is set.
// RL11 - Min and max compare unsigned words or dwords per lane.
// RL12 - Signed byte and dword min and max use two's complement order.
// RL13 - Single lane extract returns immediate-selected dword to scalar port.
// RL14 - Single lane insert places value at chosen lane, zeroes masked lanes.
// RL15 - Byte, dword, qword insert write scalar value into one element.
// RL16 - Byte to qword extract copy one element to scalar port.
// RL17 - Sign widening extends low packed elements into wider lanes.
// RL18 - Zero widening extends low packed elements into wider lanes.
// RL19 - Shuffle index is four bits at 128 and three at 64 bits.
// RL20 - Sign op keeps element for positive source, clears it for zero.
`ifndef PSP_MAP_SVH
`define PSP_MAP_SVH

// ****************************************
// Lane widths
// ****************************************
`define PSP_B_W 8
`define PSP_W_W 16
`define PSP_D_W 32
`define PSP_Q_W 64
`define PSP_V_W 128
`define PSP_IMM_W 8
`define PSP_NBYTES 16
`define PSP_NWORDS 8
`define PSP_NDWORDS 4
`define PSP_NQWORDS 2
`define PSP_HALF_BYTES 8

// ****************************************
// Field positions
// ****************************************
`define PSP_IDX128_W 4
`define PSP_IDX64_W 3
`define PSP_INS_SRC_HI 7
`define PSP_INS_SRC_LO 6
`define PSP_INS_DST_HI 5
`define PSP_INS_DST_LO 4

// ****************************************
// Reset values
// ****************************************
`define PSP_RST_VEC 128'h0
`define PSP_RST_SCALAR 64'h0

`endif

// ==== core/psp_pkg.sv ====
// Types shared by the permute datapath modules.
// Assumes psp_map.svh is on the include path.
`include "psp_map.svh"
package psp_pkg;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [5:0] {
    byte_shuffle_op, packed_sign_byte_op, packed_sign_word_op,
    packed_sign_dword_op, align_right_op, dword_mul_low_op,
    dword_mul_wide_op, blend_double_imm_op, blend_single_imm_op,
    blend_word_imm_op, blend_double_mask_op, blend_single_mask_op,
    blend_byte_mask_op, min_unsigned_word_op, min_unsigned_dword_op,
    min_signed_byte_op, min_signed_dword_op, max_unsigned_word_op,
    max_unsigned_dword_op, max_signed_byte_op, max_signed_dword_op,
    single_lane_extract_op, single_lane_insert_op, byte_insert_op,
    dword_insert_op, qword_insert_op, byte_extract_op, word_extract_op,
    dword_extract_op, qword_extract_op, sext_byte_to_word_op,
    zext_byte_to_word_op, sext_byte_to_dword_op, zext_byte_to_dword_op,
    sext_word_to_dword_op, zext_word_to_dword_op, sext_byte_to_qword_op,
    zext_byte_to_qword_op, sext_word_to_qword_op, zext_word_to_qword_op,
    sext_dword_to_qword_op, zext_dword_to_qword_op
  } psp_op_t;

  // Lane size for the compare unit
  typedef enum logic [1:0] {
    psp_sz_byte, psp_sz_word, psp_sz_dword
  } psp_size_t;

  // Whole registered state of the datapath
  typedef struct packed {
    logic valid;
    logic [`PSP_V_W-1:0] vec;
    logic [`PSP_Q_W-1:0] scalar;
  } psp_state_t;

endpackage

// ==== core/psp_minmax.sv ====
// Per-lane min/max compare unit, purely combinational.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`include "psp_map.svh"
module psp_minmax (
  // Operands
  input wire logic [`PSP_V_W-1:0] a,
  input wire logic [`PSP_V_W-1:0] b,
  // Variant
  input wire psp_pkg::psp_size_t lane_size,
  input wire logic is_signed,
  input wire logic take_max,
  // Result
  output logic [`PSP_V_W-1:0] res
);

  localparam int B = `PSP_B_W;
  localparam int W = `PSP_W_W;
  localparam int D = `PSP_D_W;
  localparam int Q = `PSP_Q_W;

  // ****************************************
  // Compare helper
  // ****************************************
  // Flipping the msb of extended values lets one unsigned compare serve both
  function automatic logic take_y(input logic [Q-1:0] x,
                                  input logic [Q-1:0] y,
                                  input logic sgn,
                                  input logic mx);
    logic [Q-1:0] fx;
    logic [Q-1:0] fy;
    fx = {x[Q-1] ^ sgn, x[Q-2:0]};
    fy = {y[Q-1] ^ sgn, y[Q-2:0]};
    take_y = mx ? (fx < fy) : (fy < fx);
  endfunction

  wire logic [`PSP_V_W-1:0] r8;
  wire logic [`PSP_V_W-1:0] r16;
  wire logic [`PSP_V_W-1:0] r32;

  // ****************************************
  // Lanes
  // ****************************************
  for (genvar i = 0; i < `PSP_NBYTES; i++)
  begin : g_lane
    wire logic [Q-1:0] xb = is_signed ? Q'($signed(a[B*i +: B]))
                                      : Q'(a[B*i +: B]);
    wire logic [Q-1:0] yb = is_signed ? Q'($signed(b[B*i +: B]))
                                      : Q'(b[B*i +: B]);
    assign r8[B*i +: B] = take_y(xb, yb, is_signed, take_max) ?
                          b[B*i +: B] : a[B*i +: B]; // RL12
    if (i < `PSP_NWORDS)
    begin : g_w
      wire logic [Q-1:0] xw = Q'(a[W*i +: W]);
      wire logic [Q-1:0] yw = Q'(b[W*i +: W]);
      assign r16[W*i +: W] = take_y(xw, yw, 1'b0, take_max) ?
                             b[W*i +: W] : a[W*i +: W]; // RL11
    end
    if (i < `PSP_NDWORDS)
    begin : g_d
      wire logic [Q-1:0] xd = is_signed ? Q'($signed(a[D*i +: D]))
                                        : Q'(a[D*i +: D]);
      wire logic [Q-1:0] yd = is_signed ? Q'($signed(b[D*i +: D]))
                                        : Q'(b[D*i +: D]);
      assign r32[D*i +: D] = take_y(xd, yd, is_signed, take_max) ?
                             b[D*i +: D] : a[D*i +: D]; // RL11
    end
  end

  // Lane size picks one of the three results
  always_comb
  begin
    case (lane_size)
      psp_pkg::psp_sz_byte: res = r8;
      psp_pkg::psp_sz_word: res = r16;
      default: res = r32;
    endcase
  end

endmodule

// ==== verif/psp_issue_model.sv ====
// Issue-side model: presents operations and operands to the datapath.
// Assumes its tasks are called just after a falling edge of mclk.
`timescale 1ns/1ps
`include "psp_map.svh"
module psp_issue_model (
  // Issue side
  output logic issue_valid,
  output psp_pkg::psp_op_t issue_op,
  output logic narrow64,
  output logic src_is_mem,
  output logic [`PSP_IMM_W-1:0] imm,
  output logic [`PSP_V_W-1:0] dst_a,
  output logic [`PSP_V_W-1:0] src_b,
  output logic [`PSP_V_W-1:0] mask_m,
  output logic [`PSP_Q_W-1:0] gpr_in
);
  // Quiet bus at time zero
  initial
  begin
    issue_valid = 1'b0;
    issue_op = psp_pkg::byte_shuffle_op;
    {narrow64, src_is_mem, imm, dst_a, src_b, mask_m, gpr_in} = '0;
  end

  // One operation; stays on the bus until the next call
  task automatic send(input psp_pkg::psp_op_t op, input logic n, mem,
                      input logic [7:0] im, input logic [127:0] a, b, m,
                      input logic [63:0] g);
    issue_valid = 1'b1;
    issue_op = op;
    {narrow64, src_is_mem, imm, dst_a, src_b, mask_m, gpr_in} =
      {n, mem, im, a, b, m, g};
  endtask

  // Released operands flip, so stale data can never pass for a result
  task automatic idle();
    issue_valid = 1'b0;
    {imm, dst_a, src_b, mask_m, gpr_in} = ~{imm, dst_a, src_b, mask_m, gpr_in};
  endtask
endmodule

// ==== verif/psp_datapath_bench.sv ====
// Self-checking bench for the permute datapath, random and corner cases.
// Assumes the issue model drives inputs at the falling edge.
`timescale 1ns/1ps
`include "psp_map.svh"
module psp_datapath_bench;
  logic mclk, rst, issue_valid, narrow64, src_is_mem, res_valid;
  psp_pkg::psp_op_t issue_op;
  logic [7:0] imm;
  logic [127:0] dst_a, src_b, mask_m, vec_out, a, b, last_v;
  logic [63:0] gpr_in, gpr_out;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 32'h05E3905D;

  psp_issue_model psp_issue_model_inst (.issue_valid(issue_valid),
    .issue_op(issue_op), .narrow64(narrow64), .src_is_mem(src_is_mem),
    .imm(imm), .dst_a(dst_a), .src_b(src_b), .mask_m(mask_m),
    .gpr_in(gpr_in));
  psp_datapath psp_datapath_inst (.mclk(mclk), .rst(rst),
    .issue_valid(issue_valid), .issue_op(issue_op), .narrow64(narrow64),
    .src_is_mem(src_is_mem), .imm(imm), .dst_a(dst_a), .src_b(src_b),
    .mask_m(mask_m), .gpr_in(gpr_in), .res_valid(res_valid),
    .vec_out(vec_out), .gpr_out(gpr_out));

  // 20 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ****************************************
  // Lane helpers and expected results
  // ****************************************
  function automatic logic [63:0] msk(int es);
    return (es == 8) ? '1 : ((64'h1 << (es * 8)) - 64'h1);
  endfunction
  function automatic logic [63:0] fld(logic [127:0] v, int es, int i);
    logic [127:0] t;
    t = v >> (i * es * 8);
    return t[63:0] & msk(es);
  endfunction
  function automatic logic [63:0] sx(logic [63:0] x, int es);
    return x[es * 8 - 1] ? (x | ~msk(es)) : x;
  endfunction
  function automatic logic [127:0] put(logic [127:0] v, int es, int i,
                                       logic [63:0] x);
    logic [127:0] mm;
    mm = {64'h0, msk(es)} << (i * es * 8);
    return (v & ~mm) | ({64'h0, x & msk(es)} << (i * es * 8));
  endfunction
  function automatic void calc(int k, logic n, mem, logic [7:0] im,
    logic [127:0] a, b, m, logic [63:0] g,
    output logic [127:0] v, output logic [63:0] r);
    int es;
    int j;
    logic [63:0] x, y, s;
    logic [255:0] pr;
    int ws[6] = '{1, 1, 2, 1, 2, 4};
    int wd[6] = '{2, 4, 4, 8, 8, 8};
    v = a;
    r = 64'h0;
    case (k) inside
      0:
        for (int i = 0; i < 16; i++)
          v = put(v, 1, i, (b[8 * i + 7] || (n && i > 7)) ? 64'h0 :
                fld(a, 1, int'(b[8 * i +: 4] & (n ? 4'h7 : 4'hF))));
      [1:3]:
      begin
        es = 1 << (k - 1);
        for (int i = 0; i < 16 / es; i++)
        begin
          x = fld(a, es, i);
          y = fld(b, es, i);
          v = put(v, es, i, y[es * 8 - 1] ? -x : ((y == 0) ? 64'h0 : x));
        end
        v[127:64] = n ? 64'h0 : v[127:64];
      end
      4:
      begin
        pr = n ? {128'h0, a[63:0], b[63:0]} >> (8 * im) : {a, b} >> (8 * im);
        v = n ? {64'h0, pr[63:0]} : pr[127:0];
      end
      [5:6]:
        for (int i = 0; i < 14 - 2 * k; i++)
        begin
          j = (k == 5) ? i : 2 * i;
          v = put(v, 4 * (k - 4), i, sx(fld(a, 4, j), 4) * sx(fld(b, 4, j), 4));
        end
      [7:12]:
      begin
        es = (k % 3 == 1) ? 8 : (k % 3 == 2) ? 4 : (k == 9) ? 2 : 1;
        for (int i = 0; i < 16 / es; i++)
          if ((k < 10) ? im[i] : m[8 * es * (i + 1) - 1])
            v = put(v, es, i, fld(b, es, i));
      end
      [13:20]:
      begin
        j = (k - 13) % 4;
        es = (j == 0) ? 2 : (j == 2) ? 1 : 4;
        s = (j >= 2) ? 64'h1 << (8 * es - 1) : 64'h0;
        for (int i = 0; i < 16 / es; i++)
        begin
          x = fld(a, es, i) ^ s;
          y = fld(b, es, i) ^ s;
          if ((k >= 17) ? (x < y) : (y < x))
            v = put(v, es, i, fld(b, es, i));
        end
      end
      21, [26:29]:
      begin
        es = (k == 21) ? 4 : (1 << (k - 26));
        r = fld(b, es, int'(im) % (16 / es));
      end
      22:
      begin
        v = put(v, 4, int'(im[5:4]),
                mem ? {32'h0, g[31:0]} : fld(b, 4, int'(im[7:6])));
        for (int i = 0; i < 4; i++)
          v = im[i] ? put(v, 4, i, 64'h0) : v;
      end
      [23:25]:
      begin
        es = (k == 23) ? 1 : 4 * (k - 23);
        v = put(v, es, int'(im) % (16 / es), g);
      end
      default:
      begin
        j = (k - 30) / 2;
        for (int i = 0; i < 16 / wd[j]; i++)
          v = put(v, wd[j], i, (k % 2 == 0) ? sx(fld(b, ws[j], i), ws[j]) :
                fld(b, ws[j], i));
      end
    endcase
  endfunction

  // ****************************************
  // Checking and issue tasks
  // ****************************************
  task automatic chk(input logic [192:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  // One issue; result looked at in its single valid cycle
  task automatic run(int k, logic n, mem, logic [7:0] im,
                     logic [127:0] a, b, m, logic [63:0] g);
    logic [63:0] er;
    psp_issue_model_inst.send(psp_pkg::psp_op_t'(k), n, mem, im, a, b, m, g);
    calc(k, n, mem, im, a, b, m, g, last_v, er);
    @(negedge mclk);
    chk(res_valid, 128'h1, "result pulse");
    chk(vec_out, last_v, "vector result");
    chk(gpr_out, {64'h0, er}, "scalar result");
  endtask
  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog: the run needs about a thousand cycles, this allows forty
  initial
  begin
    #2000000;
    n_fail++;
    conclude();
  end

  // Main sequence, back to back issues except the one idle cycle before the hold check
  initial
  begin
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    chk({res_valid, vec_out, gpr_out}, 128'h0, "reset state");
    rst = 1'b0;
    a = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
    b = 128'h8F0F_1E7F_0001_0203_FF80_1234_5678_9A0B;
    run(0, 1'b0, 1'b0, 8'h0, a, b, b, 64'h0);
    run(0, 1'b1, 1'b0, 8'h0, a, b, b, 64'h0);
    b = 128'hFF00_7F80_0000_0000_8000_0001_FFFF_0100;
    for (int k = 1; k < 4; k++)
      run(k, k == 2, 1'b0, 8'h0, a, b, b, 64'h0);
    for (int s = 0; s < 40; s += 8)
      run(4, s == 8 || s == 24, 1'b0, 8'(s), a, b, b, 64'h0);
    $display("test shuffle sign align done");
    a = 128'h8000_0000_FFFF_FFFF_7FFF_FFFF_0000_0002;
    b = {a[63:0], a[127:64]};
    for (int k = 5; k < 21; k++)
      run(k, 1'b0, 1'b0, 8'hA5, a, b, b, 64'h0);
    $display("test multiply blend minmax done");
    for (int r = 0; r < 840; r++)
      run(r % 42, (r % 42 < 5) ? 1'($random(seed)) : 1'b0, 1'($random(seed)),
          8'($random(seed)), rnd(), rnd(), rnd(), 64'(rnd()));
    $display("test random sweep done");
    psp_issue_model_inst.idle();
    @(negedge mclk);
    chk({res_valid, vec_out, gpr_out}, {1'b0, last_v, 64'h0},
        "hold after pulse");
    run(22, 1'b0, 1'b1, 8'h35, a, b, b, 64'h1234_5678_9ABC_DEF0);
    rst = 1'b1;
    @(negedge mclk);
    chk({res_valid, vec_out, gpr_out}, 128'h0, "second reset");
    rst = 1'b0;
    $display("test hold and reset done");
    conclude();
  end
endmodule
